/* File: design/ewp_consts.vh */
/*
 File: constants for the host-side write controller of a byte-wide parallel EEPROM.
 Assumes: included by bare name from the design files; 40 MHz system clock.
*/
`ifndef EWP_CONSTS_VH
`define EWP_CONSTS_VH

// Clock period in ns
`define EWP_CLK_NS          25
// Glitch limit on control pins, ns; strobes are kept clean of anything this short
`define EWP_GLITCH_NS       20
// Strobe low time: well above the glitch limit and the 250 ns minimum pulse
`define EWP_STB_NS          300
`define EWP_STB_CYC         ((`EWP_STB_NS + `EWP_CLK_NS - 1) / `EWP_CLK_NS)
// Strobe high gap between byte loads, ns
`define EWP_GAP_NS          600
`define EWP_GAP_CYC         ((`EWP_GAP_NS + `EWP_CLK_NS - 1) / `EWP_CLK_NS)
// Byte load limit from previous strobe fall, us (longest time, rounds down)
`define EWP_BLC_US          30
`define EWP_BLC_CYC         ((`EWP_BLC_US * 1000) / `EWP_CLK_NS)
// Write start window after last load, us
`define EWP_BLW_US          100
`define EWP_BLW_CYC         ((`EWP_BLW_US * 1000 + `EWP_CLK_NS - 1) / `EWP_CLK_NS)
// Guard hold after last data byte, ms
`define EWP_HOLD_MS         10
`define EWP_HOLD_CYC        ((`EWP_HOLD_MS * 1000000 + `EWP_CLK_NS - 1) / `EWP_CLK_NS)

// Command sequence addresses and data
`define EWP_ADR_5555        17'h05555
`define EWP_ADR_2AAA        17'h02AAA
`define EWP_DAT_AA          8'hAA
`define EWP_DAT_55          8'h55
`define EWP_DAT_A0          8'hA0
`define EWP_DAT_80          8'h80
`define EWP_DAT_20          8'h20

// Host command codes
`define EWP_CMD_WRITE       2'h0
`define EWP_CMD_ARM         2'h1
`define EWP_CMD_DISARM      2'h2

`endif

/* File: design/ewp_host_ctrl.v */
/*
 File: host-side controller driving a byte-wide parallel EEPROM through its pins.
   Issues byte writes, software-lock arm (with data) and disarm sequences.
 Assumes: one 40 MHz clock; ready/busy pin has an external pull-up; cpu_rst_n
   is the system processor reset and is already clean on this clock.
*/
// How it works
// - Strobes are registered, never glitch, and pulse far beyond 20 ns.
// - Guard pin follows processor reset one clock later through a flop, low during power ramps.
// - Guard pin forced high for 10 ms after the last data byte.
// - Arm: AA@5555, 55@2AAA, A0@5555, then the data write.
// - Every write while locked is preceded by the three-byte arm code.
// - Disarm: AA, 55, 80, AA, 55, 20 at 5555/2AAA/5555 addresses.
// - Next load within 30 us of last fall; 100 us idle starts write.
`timescale 1ns/1ps
`include "ewp_consts.vh"

module ewp_host_ctrl (
   input  wire        sys_clk,      // System clock, 40 MHz
   input  wire        arst_n,       // Asynchronous reset, active low
   input  wire        cpu_rst_n,    // Processor reset level, active low
   input  wire        req_valid,    // Command request
   output wire        req_ready,    // Controller idle, takes request
   input  wire [1:0]  req_cmd,      // Write, arm or disarm
   input  wire [16:0] req_addr,     // Write address
   input  wire [7:0]  req_data,     // Write data
   input  wire        locked_wr,    // Treat writes as needing the arm code
   output reg         done_q,       // One-cycle pulse: command finished
   output reg         lock_state_q, // Host view of the device lock
   output reg  [16:0] mem_addr_q,   // Address pins
   output reg  [7:0]  mem_dq_o_q,   // Data pins, out
   output reg         mem_dq_oe_q,  // Data pins drive enable
   output reg         mem_ce_n_q,   // Chip select, active low
   output reg         mem_we_n_q,   // Write strobe, active low
   output wire        mem_oe_n,     // Output strobe, active low
   output reg         guard_hold_n_q, // Protection input, active low
   input  wire        mem_rdy_i     // Ready/busy pin level
);

   //--------------------------------------------------------------
   // States and counters
   //--------------------------------------------------------------
   localparam ST_IDLE = 3'h0;
   localparam ST_SET  = 3'h1;   // Give the step table one cycle
   localparam ST_LOW  = 3'h2;   // Strobe low
   localparam ST_GAP  = 3'h3;   // Strobe high between loads
   localparam ST_WAIT = 3'h4;   // Wait out the load window and the busy pin

   // Counts cut to their register widths on purpose; all values fit
   localparam integer HOLD_I  = `EWP_HOLD_CYC;
   localparam integer WIN_I   = `EWP_HOLD_CYC - `EWP_BLW_CYC;
   localparam integer STB_I   = `EWP_STB_CYC;
   localparam integer GAP_I   = `EWP_GAP_CYC;
   localparam [18:0]  HOLD_LD = HOLD_I[18:0];
   localparam [18:0]  WIN_LD  = WIN_I[18:0];
   localparam [4:0]   STB_LD  = STB_I[4:0];
   localparam [4:0]   GAP_LD  = GAP_I[4:0];

   reg [2:0]  st_q;
   reg [2:0]  idx_q;        // Sequence step
   reg [2:0]  last_q;       // Last step index of this command
   reg        cmd_dis_q;    // Disarm in progress
   reg        tail_q;       // Final step is the user data byte
   reg [16:0] wr_addr_q;
   reg [7:0]  wr_data_q;
   reg [4:0]  tmr_q;        // Short strobe timing
   reg [18:0] hold_q;       // Guard hold countdown
   reg [2:0]  rdy_s_q;      // Ready/busy synchroniser
   reg        busy_s_q;     // Busy level, changes only when stages agree

   wire [16:0] rom_adr;
   wire [7:0]  rom_dat;
   wire        rdy_busy;

   // Writes never read back, so output strobe stays high
   assign mem_oe_n  = 1'b1;
   assign req_ready = (st_q == ST_IDLE) && cpu_rst_n;

   // Step table of the command codes
   ewp_seq_rom u_rom (
      .sys_clk (sys_clk),
      .arst_n  (arst_n),
      .idx     (idx_q),
      .disarm  (cmd_dis_q),
      .adr_q   (rom_adr),
      .dat_q   (rom_dat)
   );

   //--------------------------------------------------------------
   // Ready/busy sampling
   //--------------------------------------------------------------
   // Pin is asynchronous; busy counts only when stages two and three agree low
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rdy_s_q  <= 3'h7;
         busy_s_q <= 1'b0;
      end else begin
         rdy_s_q <= {rdy_s_q[1:0], mem_rdy_i};
         // Disagreeing stages keep the old level, so a slow edge counts once
         if (rdy_s_q[1] == rdy_s_q[2]) begin
            busy_s_q <= !rdy_s_q[2];
         end
      end
   end
   assign rdy_busy = busy_s_q;

   //--------------------------------------------------------------
   // Guard pin
   //--------------------------------------------------------------
   // reset follows processor
   // ten ms hold
   // Hold keeps the pin high after the last byte so the write is not cut
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         guard_hold_n_q <= 1'b0;
         hold_q         <= 19'h00000;
      end else begin
         if (st_q == ST_LOW && tmr_q == 5'h00 && idx_q == last_q) begin
            hold_q <= HOLD_LD;
         end else if (hold_q != 19'h00000) begin
            hold_q <= hold_q - 19'h00001;
         end
         guard_hold_n_q <= cpu_rst_n || (hold_q != 19'h00000);
      end
   end

   //--------------------------------------------------------------
   // Sequencer
   //--------------------------------------------------------------
   // Strobes only ever change from flops, so no pulse is shorter than a clock
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_q         <= ST_IDLE;
         idx_q        <= 3'h0;
         last_q       <= 3'h0;
         cmd_dis_q    <= 1'b0;
         tail_q       <= 1'b0;
         wr_addr_q    <= 17'h00000;
         wr_data_q    <= 8'h00;
         tmr_q        <= 5'h00;
         done_q       <= 1'b0;
         lock_state_q <= 1'b0;
         mem_addr_q   <= 17'h00000;
         mem_dq_o_q   <= 8'h00;
         mem_dq_oe_q  <= 1'b0;
         mem_ce_n_q   <= 1'b1;
         mem_we_n_q   <= 1'b1;
      end else begin
         done_q <= 1'b0;
         case (st_q)
            ST_IDLE: begin
               mem_dq_oe_q <= 1'b0;
               if (req_valid && req_ready) begin
                  wr_addr_q <= req_addr;
                  wr_data_q <= req_data;
                  cmd_dis_q <= (req_cmd == `EWP_CMD_DISARM);
                  st_q      <= ST_SET;
                  if (req_cmd == `EWP_CMD_DISARM) begin
                     idx_q        <= 3'h0;
                     last_q       <= 3'h5;
                     tail_q       <= 1'b0;
                     lock_state_q <= 1'b0;
                  end else if (req_cmd == `EWP_CMD_ARM ||
                               lock_state_q || locked_wr) begin
                     idx_q        <= 3'h0;
                     last_q       <= 3'h3;
                     tail_q       <= 1'b1;
                     // Any arm code sent locks the device, forced ones too
                     lock_state_q <= 1'b1;
                  end else begin
                     idx_q  <= 3'h3;
                     last_q <= 3'h3;
                     tail_q <= 1'b1;
                  end
               end
            end
            ST_SET: begin
               // Table output is registered: give it one cycle to follow idx_q
               tmr_q <= 5'h02;
               st_q  <= ST_LOW;
            end
            ST_LOW: begin
               if (tmr_q == 5'h02 && mem_we_n_q) begin
                  mem_addr_q  <= (tail_q && idx_q == last_q) ? wr_addr_q : rom_adr;
                  mem_dq_o_q  <= (tail_q && idx_q == last_q) ? wr_data_q : rom_dat;
                  mem_dq_oe_q <= 1'b1;
                  tmr_q       <= 5'h01;
               end else if (tmr_q == 5'h01 && mem_we_n_q) begin
                  mem_ce_n_q <= 1'b0;
                  mem_we_n_q <= 1'b0;
                  tmr_q      <= STB_LD;
               end else if (tmr_q != 5'h00) begin
                  tmr_q <= tmr_q - 5'h01;
               end else begin
                  mem_ce_n_q <= 1'b1;
                  mem_we_n_q <= 1'b1;
                  tmr_q      <= GAP_LD;
                  st_q       <= ST_GAP;
               end
            end
            ST_GAP: begin
               if (tmr_q != 5'h00) begin
                  tmr_q <= tmr_q - 5'h01;
               end else if (idx_q == last_q) begin
                  mem_dq_oe_q <= 1'b0;
                  st_q        <= ST_WAIT;
               end else begin
                  idx_q <= idx_q + 3'h1;
                  st_q  <= ST_SET;
               end
            end
            ST_WAIT: begin
               // strobes idle past the load window, then wait for ready
               // The guard hold keeps running behind later commands
               if (hold_q <= WIN_LD && !rdy_busy) begin
                  done_q <= 1'b1;
                  st_q   <= ST_IDLE;
               end
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

endmodule // ewp_host_ctrl

/* File: design/ewp_seq_rom.v */
/*
 File: small table of the command-sequence steps (address, data) the host sends.
 Assumes: read one cycle after the index is presented; registered output.
*/
`timescale 1ns/1ps
`include "ewp_consts.vh"

module ewp_seq_rom (
   input  wire        sys_clk,   // System clock
   input  wire        arst_n,    // Asynchronous reset, active low
   input  wire [2:0]  idx,       // Step index 0..5
   input  wire        disarm,    // 1: disarm table, 0: arm table
   output reg  [16:0] adr_q,     // Step address
   output reg  [7:0]  dat_q      // Step data
);

   //--------------------------------------------------------------
   // Table lookup
   //--------------------------------------------------------------
   reg [16:0] adr_d;
   reg [7:0]  dat_d;

   // Steps 1 and 4 go to the 2AAA alias; steps 0,2,3,5 go to 5555
   always @* begin
      adr_d = (idx == 3'h1 || idx == 3'h4) ? `EWP_ADR_2AAA : `EWP_ADR_5555;
      case (idx)
         3'h0: dat_d = `EWP_DAT_AA;
         3'h1: dat_d = `EWP_DAT_55;
         3'h2: dat_d = disarm ? `EWP_DAT_80 : `EWP_DAT_A0;
         3'h3: dat_d = `EWP_DAT_AA;
         3'h4: dat_d = `EWP_DAT_55;
         3'h5: dat_d = `EWP_DAT_20;
         default: dat_d = 8'h00;
      endcase
   end

   // Registered read data
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         adr_q <= 17'h00000;
         dat_q <= 8'h00;
      end else begin
         adr_q <= adr_d;
         dat_q <= dat_d;
      end
   end

endmodule // ewp_seq_rom

/* File: test/ewp_eeprom_model.sv */
/* Behavioural model of the byte-wide EEPROM with its software write lock.
   Assumes: driven by the host controller pins; ready/busy has a pull-up. */
`timescale 1ns/1ps
module ewp_eeprom_model #(parameter BUSY_NS = 50000) (
   input  wire [16:0] addr,     // Address pins
   input  wire [7:0]  dq,       // Data pins
   input  wire        ce_n,     // Chip select
   input  wire        we_n,     // Write strobe
   input  wire        guard_n,  // Protection input
   output wire        rdy       // Ready/busy, low while busy
);
   reg [7:0]  mem [0:131071];
   reg [16:0] a_q;
   reg [2:0]  st_q = 3'h0;
   reg        lock_q = 1'b0;
   reg        busy_q = 1'b0;
   integer    loads = 0;
   integer    i;
   realtime   t_fall, t_end;
   wire       sel = !ce_n && !we_n;
   initial for (i = 0; i < 131072; i = i + 1) mem[i] = 8'hFF;
   // open drain: released line reads high
   assign rdy = !busy_q;
   // busy from the programmed byte's load until the internal write ends
   task automatic prog(input [16:0] a, input [7:0] d);
      begin
         mem[a] = d;
         busy_q = 1'b1;
         t_end = $realtime + BUSY_NS;
      end
   endtask
   // command tracker, mismatch returns to idle
   task automatic load(input [16:0] a, input [7:0] d);
      reg c5, c2;
      begin
         loads = loads + 1;
         c5 = a == 17'h05555;
         c2 = a == 17'h02AAA || a == 17'h0AAAA;
         case (st_q)
            3'h0: if (c5 && d == 8'hAA) st_q = 3'h1; else if (!lock_q) prog(a, d);
            3'h1: st_q = (c2 && d == 8'h55) ? 3'h2 : 3'h0;
            3'h2: st_q = !c5 ? 3'h0 : d == 8'hA0 ? 3'h3 : d == 8'h80 ? 3'h4 : 3'h0;
            3'h3: begin lock_q = 1'b1; prog(a, d); st_q = 3'h0; end
            3'h4: st_q = (c5 && d == 8'hAA) ? 3'h5 : 3'h0;
            3'h5: st_q = (c2 && d == 8'h55) ? 3'h6 : 3'h0;
            default: begin if (c5 && d == 8'h20) lock_q = 1'b0; st_q = 3'h0; end
         endcase
      end
   endtask
   // address taken at the later falling edge
   always @(posedge sel) begin a_q = addr; t_fall = $realtime; end
   // data at first rise; short pulses and guard low ignored
   always @(negedge sel) if (guard_n && $realtime - t_fall > 20.0) load(a_q, dq);
   // internal write runs out on its own timer
   always #100 if (busy_q && $realtime >= t_end) busy_q = 1'b0;
   // guard fall aborts and spoils the byte
   always @(negedge guard_n) if (busy_q) begin mem[a_q] = ~mem[a_q]; busy_q = 1'b0; end
endmodule // ewp_eeprom_model

/* File: test/ewp_host_ctrl_checker.sv */
/* Pin-level checker for the EEPROM host controller.
   Assumes: bound to ewp_host_ctrl; one 40 MHz clock. */
`timescale 1ns/1ps
module ewp_chk (
   input wire        sys_clk,        // Clock
   input wire        arst_n,         // Reset, active low
   input wire        req_ready,      // Idle flag
   input wire [16:0] mem_addr_q,     // Address pins
   input wire [7:0]  mem_dq_o_q,     // Data pins
   input wire        mem_dq_oe_q,    // Data drive enable
   input wire        mem_ce_n_q,     // Chip select
   input wire        mem_we_n_q,     // Write strobe
   input wire        mem_oe_n,       // Output strobe
   input wire        guard_hold_n_q  // Protection pin
);
   localparam int HOLD_CYC = 400000;
   reg [18:0] hold_q;  // Cycles since last strobe rise, saturating
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   // Restart at every strobe rise; the last one opens the hold window
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) hold_q <= 19'h7FFFF;
      else if ($rose(mem_we_n_q)) hold_q <= 19'h00000;
      else if (hold_q != 19'h7FFFF) hold_q <= hold_q + 19'h00001;
   end
   chk_guard_release: assert property (req_ready |=> guard_hold_n_q)
      else $error("guard pin low while idle out of reset");
   chk_guard_hold: assert property (hold_q < HOLD_CYC |-> guard_hold_n_q)
      else $error("guard pin fell inside the hold window");
   chk_strobe_width: assert property ($fell(mem_we_n_q) |-> (!mem_we_n_q)[*8])
      else $error("write strobe pulse too short");
   chk_gap_width: assert property ($rose(mem_we_n_q) |-> mem_we_n_q[*8])
      else $error("strobe gap too short");
   chk_ce_with_we: assert property (!mem_we_n_q |-> !mem_ce_n_q)
      else $error("write strobe without chip select");
   chk_addr_stable: assert property (!mem_we_n_q ##1 !mem_we_n_q |->
      $stable(mem_addr_q) && $stable(mem_dq_o_q))
      else $error("address or data moved inside strobe");
   chk_data_hold: assert property ($rose(mem_we_n_q) |-> mem_dq_oe_q && $stable(mem_dq_o_q))
      else $error("data not held at strobe rise");
   chk_read_off: assert property (mem_oe_n)
      else $error("output strobe asserted");
endmodule // ewp_chk
bind ewp_host_ctrl ewp_chk u_chk (.sys_clk(sys_clk), .arst_n(arst_n), .req_ready(req_ready),
   .mem_addr_q(mem_addr_q), .mem_dq_o_q(mem_dq_o_q), .mem_dq_oe_q(mem_dq_oe_q),
   .mem_ce_n_q(mem_ce_n_q), .mem_we_n_q(mem_we_n_q), .mem_oe_n(mem_oe_n),
   .guard_hold_n_q(guard_hold_n_q));

/* File: test/testbench.sv */
/* Self-checking bench: host controller against the EEPROM model.
   Assumes: model busy time outlasts the load window, so done waits on ready. */
`timescale 1ns/1ps
module testbench;
   reg         sys_clk = 1'b0;
   reg         arst_n = 1'b0;
   reg         cpu_rst_n = 1'b1;
   reg         req_valid = 1'b0;
   reg         locked_wr = 1'b0;
   reg  [1:0]  req_cmd = 2'h0;
   reg  [16:0] req_addr = 17'h00000;
   reg  [7:0]  req_data = 8'h00;
   integer     mismatches = 0;
   integer     n_tests = 0;
   integer     l0;
   wire        req_ready, done_q, lock_state_q, dq_oe, ce_n, we_n, oe_n, guard_n, rdy;
   wire [16:0] addr;
   wire [7:0]  dq;
   always #12.5 sys_clk = ~sys_clk;
   ewp_host_ctrl u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .cpu_rst_n(cpu_rst_n),
      .req_valid(req_valid), .req_ready(req_ready), .req_cmd(req_cmd), .req_addr(req_addr),
      .req_data(req_data), .locked_wr(locked_wr), .done_q(done_q),
      .lock_state_q(lock_state_q), .mem_addr_q(addr), .mem_dq_o_q(dq), .mem_dq_oe_q(dq_oe),
      .mem_ce_n_q(ce_n), .mem_we_n_q(we_n), .mem_oe_n(oe_n), .guard_hold_n_q(guard_n),
      .mem_rdy_i(rdy));
   // Released data pins show the inverse of the last value
   ewp_eeprom_model #(.BUSY_NS(150000)) u_eep (.addr(addr), .dq(dq_oe ? dq : ~dq),
      .ce_n(ce_n), .we_n(we_n),
      .guard_n(guard_n), .rdy(rdy));
   task check(input [8*8-1:0] what, input [31:0] exp, input [31:0] got);
      begin
         n_tests = n_tests + 1;
         if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("unexpected %0s expected %0h seen %0h", what, exp, got);
         end
      end
   endtask
   task finish_test;
      begin
         $display("comparisons %0d mismatches %0d", n_tests, mismatches);
         if (mismatches == 0 && n_tests > 0) $display("*** PASS ***");
         else $display("*** FAIL ***");
         $finish;
      end
   endtask
   // One request, held across the taking edge, then a bounded wait for done
   task cmd(input [1:0] c, input [16:0] a, input [7:0] d);
      integer n;
      begin
         n = 0;
         l0 = u_eep.loads;
         @(negedge sys_clk);
         while (req_ready !== 1'b1 && n < 100) begin @(negedge sys_clk); n = n + 1; end
         if (n >= 100) begin
            mismatches = mismatches + 1;
            finish_test;
         end
         req_cmd = c;
         req_addr = a;
         req_data = d;
         req_valid = 1'b1;
         @(negedge sys_clk);
         req_valid = 1'b0;
         n = 0;
         // Done stands one cycle; the falling edge sees it mid-cycle
         while (done_q !== 1'b1 && n < 20000) begin @(negedge sys_clk); n = n + 1; end
         if (n >= 20000) begin
            mismatches = mismatches + 1;
            finish_test;
         end
      end
   endtask
   task t_write;
      begin
         cmd(2'h0, 17'h00123, 8'h5A);
         check("mem", 8'h5A, u_eep.mem[17'h00123]);
         check("loads", 1, u_eep.loads - l0);
         check("lock", 1'b0, lock_state_q);
         check("busy", 1'b0, u_eep.busy_q);
         $display("test plain write done");
      end
   endtask
   task t_arm;
      begin
         cmd(2'h1, 17'h01000, 8'h3C);
         check("loads", 4, u_eep.loads - l0);
         check("mem", 8'h3C, u_eep.mem[17'h01000]);
         check("devlock", 1'b1, u_eep.lock_q);
         check("lock", 1'b1, lock_state_q);
         cmd(2'h0, 17'h01001, 8'hC3);
         check("loads", 4, u_eep.loads - l0);
         check("mem", 8'hC3, u_eep.mem[17'h01001]);
         $display("test arm and locked write done");
      end
   endtask
   task t_disarm;
      begin
         cmd(2'h2, 17'h00000, 8'h00);
         check("loads", 6, u_eep.loads - l0);
         check("devlock", 1'b0, u_eep.lock_q);
         check("lock", 1'b0, lock_state_q);
         $display("test disarm done");
      end
   endtask
   task t_guard;
      begin
         @(negedge sys_clk);
         cpu_rst_n = 1'b0;
         repeat (3) @(negedge sys_clk);
         check("ready", 1'b0, req_ready);
         check("guard", 1'b0, guard_n);
         cpu_rst_n = 1'b1;
         repeat (3) @(negedge sys_clk);
         check("guard", 1'b1, guard_n);
         $display("test guard follows reset done");
      end
   endtask
   // Forced arm code on a write while the host thinks the device is open
   task t_locked;
      begin
         locked_wr = 1'b1;
         cmd(2'h0, 17'h00200, 8'h77);
         locked_wr = 1'b0;
         check("loads", 4, u_eep.loads - l0);
         check("mem", 8'h77, u_eep.mem[17'h00200]);
         check("devlock", 1'b1, u_eep.lock_q);
         check("lock", 1'b1, lock_state_q);
         $display("test forced arm code write done");
      end
   endtask
   // Guard test first: no guard hold is running yet
   initial begin
      repeat (3) @(negedge sys_clk);
      arst_n = 1'b1;
      t_guard;
      t_write;
      t_arm;
      t_disarm;
      t_locked;
      finish_test;
   end
endmodule // testbench
